/* include/fdi_pkg.sv */
/*
  Shared constants and types for the diskette drive interface controller.
  Assumes a 25 MHz system clock and an AXI4-Lite register master.
*/
package fdi_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEEK = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_FIFO = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_FILL = 8'h18;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_SEL = 0;
  localparam int CTRL_MOTOR = 1;
  localparam int CTRL_DIR_OUT = 2;
  localparam int CTRL_HEAD1 = 3;
  localparam int CTRL_CAP144 = 4;
  localparam int CTRL_WRITE = 5;
  localparam int CTRL_RATE250 = 6;
  localparam int CTRL_BURST = 7;
  localparam int CTRL_SWAP_ACK = 8;
  localparam logic [8:0] CTRL_RESET = 9'h010;

  // ------------------------------------------------------------------
  // Interrupt bits
  // ------------------------------------------------------------------
  localparam int IRQ_INDEX = 0;
  localparam int IRQ_SEEK_DONE = 1;
  localparam int IRQ_SWAPPED = 2;
  localparam int IRQ_WP_ERR = 3;
  localparam int IRQ_FIFO = 4;
  localparam int IRQ_W = 5;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int RATE_FAST_BPS = 500_000;
  localparam int RATE_SLOW_BPS = 250_000;
  localparam int BIT_FAST = CLK_HZ / RATE_FAST_BPS;
  localparam int BIT_SLOW = CLK_HZ / RATE_SLOW_BPS;
  localparam int STEP_PULSE_NS = 4000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * 25 + 999) / 1000;
  localparam int STEP_GAP_NS = 3_000_000;
  localparam int STEP_GAP_CYC = (STEP_GAP_NS / 1000) * 25;
  localparam int FIFO_DEPTH = 16;
  localparam int BURST_LEVEL = 8;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {SK_IDLE, SK_PULSE, SK_GAP} fdi_seek_t;

  typedef struct packed {
    logic sel_n;
    logic motor_n;
    logic dir_out;
    logic step_n;
    logic head_sel;
    logic cap_sel;
    logic rec_en_n;
    logic wr_data;
  } fdi_drv_out_t;

  typedef struct packed {
    logic index_n;
    logic outer_cyl_n;
    logic wp_n;
    logic hd_n;
    logic swapped_n;
    logic rd_data;
  } fdi_drv_in_t;

endpackage

/* core/fdi_ctrl.sv */
/*
  Diskette drive interface controller: AXI4-Lite register slave, drive
  control pins, seek stepper, serial bit engine and 16-byte data FIFO.
  Assumes drive inputs already synchronous to aclk; one clock domain.
*/
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fdi_ctrl (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive pins
  input wire fdi_pkg::fdi_drv_in_t drv_in,
  output fdi_pkg::fdi_drv_out_t drv_out,
  // Interrupt
  output logic irq
);
  import fdi_pkg::*;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [8:0] ctrl_ff;
  logic [7:0] seek_cnt_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic [7:0] fifo_mem_ff [FIFO_DEPTH];
  logic [3:0] wr_ptr_ff, rd_ptr_ff;
  logic [4:0] fill_ff;
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  fdi_seek_t seek_st_ff;
  logic [16:0] seek_tmr_ff;
  logic [7:0] bit_tmr_ff;
  logic [2:0] bit_idx_ff;
  logic [7:0] sh_ff;
  logic wr_bit_ff;
  logic index_d_ff, swap_d_ff, swap_hold_ff;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic wr_go, rd_go, fifo_push_bus, fifo_pop_bus, wp_hit, write_ok;
  logic bit_tick, byte_done, fifo_full, fifo_empty;
  logic [IRQ_W-1:0] ev;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign wr_go = clk_en && aw_ff && w_ff && !bvalid_ff;
  assign rd_go = clk_en && s_axi_arvalid && !rvalid_ff;
  assign fifo_full = fill_ff == 5'(FIFO_DEPTH);
  assign fifo_empty = fill_ff == 5'h00;
  assign fifo_push_bus = wr_go && awaddr_ff == ADDR_FIFO && !fifo_full
                         && wstrb_ff[0];
  assign fifo_pop_bus = rd_go && s_axi_araddr == ADDR_FIFO && !fifo_empty;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read data; unmapped addresses answer OKAY with zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        case (s_axi_araddr)
          ADDR_CTRL: rdata_ff <= {23'h0, ctrl_ff};
          ADDR_SEEK: rdata_ff <= {24'h0, seek_cnt_ff};
          ADDR_STAT: rdata_ff <= {26'h0, seek_st_ff != SK_IDLE,
                                  !drv_in.hd_n, !drv_in.swapped_n,
                                  !drv_in.wp_n, !drv_in.outer_cyl_n,
                                  !drv_in.index_n};
          ADDR_FIFO: rdata_ff <= {24'h0, fifo_mem_ff[rd_ptr_ff]};
          ADDR_IRQ_STAT: rdata_ff <= {27'h0, irq_stat_ff};
          ADDR_IRQ_MASK: rdata_ff <= {27'h0, irq_mask_ff};
          ADDR_FILL: rdata_ff <= {27'h0, fill_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Control and mask registers
  // ------------------------------------------------------------------
  // write mode refused on protected media
  assign wp_hit = wr_go && awaddr_ff == ADDR_CTRL && wstrb_ff[0]
                  && wdata_ff[CTRL_WRITE] && !drv_in.wp_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RESET;
      irq_mask_ff <= '0;
    end else if (clk_en) begin
      if (wr_go && awaddr_ff == ADDR_CTRL) begin
        ctrl_ff <= 9'(merge({23'h0, ctrl_ff}, wdata_ff, wstrb_ff));
        if (wp_hit) begin
          ctrl_ff[CTRL_WRITE] <= 1'b0;
        end
      end else begin
        // drop write mode if protect appears
        if (!drv_in.wp_n) begin
          ctrl_ff[CTRL_WRITE] <= 1'b0;
        end
        // Acknowledge is a one-shot request
        ctrl_ff[CTRL_SWAP_ACK] <= 1'b0;
      end
      if (wr_go && awaddr_ff == ADDR_IRQ_MASK && wstrb_ff[0]) begin
        irq_mask_ff <= wdata_ff[IRQ_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Seek stepper
  // ------------------------------------------------------------------
  // Step gap is long so the drive can settle between cylinders
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seek_st_ff <= SK_IDLE;
      seek_cnt_ff <= 8'h00;
      seek_tmr_ff <= '0;
    end else if (clk_en) begin
      case (seek_st_ff)
        SK_IDLE: begin
          if (wr_go && awaddr_ff == ADDR_SEEK && wstrb_ff[0]) begin
            seek_cnt_ff <= wdata_ff[7:0];
          end else if (seek_cnt_ff != 8'h00 && ctrl_ff[CTRL_SEL]) begin
            seek_st_ff <= SK_PULSE;
            seek_tmr_ff <= 17'(STEP_PULSE_CYC - 1);
          end
        end
        SK_PULSE: begin
          if (seek_tmr_ff == '0) begin
            seek_st_ff <= SK_GAP;
            seek_cnt_ff <= seek_cnt_ff - 8'h01;
            seek_tmr_ff <= 17'(STEP_GAP_CYC - 1);
          end else begin
            seek_tmr_ff <= seek_tmr_ff - 17'h00001;
          end
        end
        SK_GAP: begin
          if (seek_tmr_ff == '0) begin
            seek_st_ff <= SK_IDLE;
          end else begin
            seek_tmr_ff <= seek_tmr_ff - 17'h00001;
          end
        end
        default: seek_st_ff <= SK_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Serial bit engine and FIFO
  // ------------------------------------------------------------------
  // bit period from selected rate
  assign bit_tick = bit_tmr_ff == 8'h00;
  assign byte_done = bit_tick && bit_idx_ff == 3'h7
                     && ctrl_ff[CTRL_SEL] && ctrl_ff[CTRL_MOTOR] == 1'b1;
  assign write_ok = ctrl_ff[CTRL_WRITE] && drv_in.wp_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_tmr_ff <= 8'h00;
      bit_idx_ff <= 3'h0;
      sh_ff <= 8'h00;
      wr_bit_ff <= 1'b0;
    end else if (clk_en) begin
      if (bit_tick) begin
        bit_tmr_ff <= ctrl_ff[CTRL_RATE250] ? 8'(BIT_SLOW - 1)
                                            : 8'(BIT_FAST - 1);
        bit_idx_ff <= bit_idx_ff + 3'h1;
        if (write_ok) begin
          wr_bit_ff <= fifo_empty ? 1'b0 : fifo_mem_ff[rd_ptr_ff][bit_idx_ff];
        end else begin
          sh_ff <= {drv_in.rd_data, sh_ff[7:1]};
          wr_bit_ff <= 1'b0;
        end
      end else begin
        bit_tmr_ff <= bit_tmr_ff - 8'h01;
      end
    end
  end

  // 16-byte FIFO between bus and disk
  logic eng_push, eng_pop, push, pop;
  assign eng_push = byte_done && !write_ok && !fifo_full;
  assign eng_pop = byte_done && write_ok && !fifo_empty;
  assign push = fifo_push_bus || eng_push;
  assign pop = fifo_pop_bus || eng_pop;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      fill_ff <= 5'h00;
    end else if (clk_en) begin
      if (push) begin
        fifo_mem_ff[wr_ptr_ff] <= eng_push ? sh_ff : wdata_ff[7:0];
        wr_ptr_ff <= wr_ptr_ff + 4'h1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 4'h1;
      end
      fill_ff <= fill_ff + 5'(push) - 5'(pop);
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic fifo_req, stat_rd;
  // burst waits for half fill, else per byte
  assign fifo_req = ctrl_ff[CTRL_BURST]
    ? (write_ok ? fill_ff <= 5'(BURST_LEVEL) : fill_ff >= 5'(BURST_LEVEL))
    : (write_ok ? !fifo_full : !fifo_empty);
  always_comb begin
    ev = '0;
    ev[IRQ_INDEX] = index_d_ff && !drv_in.index_n;
    ev[IRQ_SEEK_DONE] = seek_st_ff == SK_GAP && seek_cnt_ff == 8'h00
                        && seek_tmr_ff == '0;
    ev[IRQ_SWAPPED] = swap_d_ff && !drv_in.swapped_n;
    ev[IRQ_WP_ERR] = wp_hit;
    ev[IRQ_FIFO] = fifo_req && ctrl_ff[CTRL_MOTOR];
  end
  assign stat_rd = rd_go && s_axi_araddr == ADDR_IRQ_STAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= '0;
      index_d_ff <= 1'b1;
      swap_d_ff <= 1'b1;
      swap_hold_ff <= 1'b0;
    end else if (clk_en) begin
      index_d_ff <= drv_in.index_n;
      swap_d_ff <= drv_in.swapped_n;
      // Set wins over the read clear
      irq_stat_ff <= (stat_rd ? '0 : irq_stat_ff) | ev;
      // acknowledge pulse held until drive releases
      if (ctrl_ff[CTRL_SWAP_ACK]) begin
        swap_hold_ff <= 1'b1;
      end else if (drv_in.swapped_n) begin
        swap_hold_ff <= 1'b0;
      end
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ------------------------------------------------------------------
  // Drive pins
  // ------------------------------------------------------------------
  logic any_sel;
  assign any_sel = ctrl_ff[CTRL_SEL];
  always_comb begin
    // unit select gates the motor, write gate and write data outputs
    drv_out.sel_n = !any_sel || swap_hold_ff;
    drv_out.motor_n = !(any_sel && ctrl_ff[CTRL_MOTOR]);
    drv_out.dir_out = ctrl_ff[CTRL_DIR_OUT];
    drv_out.step_n = seek_st_ff != SK_PULSE;
    drv_out.head_sel = !ctrl_ff[CTRL_HEAD1];
    drv_out.cap_sel = ctrl_ff[CTRL_CAP144];
    drv_out.rec_en_n = !(any_sel && write_ok);
    drv_out.wr_data = wr_bit_ff && any_sel && write_ok;
  end

  // No dedicated pin: acknowledge is a deselect held until the drive releases swapped_n

endmodule // fdi_ctrl
`default_nettype wire

/* tb/fdi_ctrl_sva.sv */
/* Port checker for fdi_ctrl.
   Assumes clk_en stays high while checked traffic runs. */
`timescale 1ns/1ns
`default_nettype none
module fdi_ctrl_sva
  import fdi_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Drive and interrupt
  input wire fdi_drv_in_t drv_in,
  input wire fdi_drv_out_t drv_out,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] low_ff;
  // Saturates so a stuck pulse cannot wrap into a match
  always_ff @(posedge aclk) begin
    if (!aresetn || drv_out.step_n) low_ff <= 8'h00;
    else if (low_ff != 8'hFF) low_ff <= low_ff + 8'h01;
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_step_end;
    $rose(drv_out.step_n) && $past(aresetn);
  endsequence
  property p_resp;
    s_wr_taken |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_awblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_sel;
    !drv_out.step_n |-> !drv_out.sel_n;
  endproperty
  property p_pulse;
    s_step_end |-> low_ff == STEP_PULSE_CYC;
  endproperty
  property p_dir;
    !drv_out.step_n && !$past(drv_out.step_n) |-> $stable(drv_out.dir_out);
  endproperty
  property p_wp;
    !drv_in.wp_n && clk_en |=> drv_out.rec_en_n;
  endproperty
  property p_wgate;
    drv_out.rec_en_n |-> !drv_out.wr_data;
  endproperty
  property p_idle;
    $rose(aresetn) |-> !irq && drv_out.motor_n && drv_out.rec_en_n;
  endproperty
  a_resp: assert property (p_resp)
    else $error("write response late");
  a_awblk: assert property (p_awblk)
    else $error("write taken during response");
  a_rd: assert property (p_rd)
    else $error("read data late");
  a_arblk: assert property (p_arblk)
    else $error("read taken during data");
  a_sel: assert property (p_sel)
    else $error("step without select");
  a_pulse: assert property (p_pulse)
    else $error("step pulse width");
  a_dir: assert property (p_dir)
    else $error("direction moved in pulse");
  a_wp: assert property (p_wp)
    else $error("write gate on protected disk");
  a_wgate: assert property (p_wgate)
    else $error("write data outside gate");
  a_idle: assert property (p_idle)
    else $error("pins not idle after reset");
endmodule // fdi_ctrl_sva
bind fdi_ctrl fdi_ctrl_sva u_sva (.aclk, .aresetn, .clk_en,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .drv_in, .drv_out, .irq);
`default_nettype wire

/* tb/fdi_drive_model.sv */
/* Behavioural diskette drive for the bench.
   Assumes pins change just after aclk edges; pull-ups on status. */
`timescale 1ns/1ns
`default_nettype none
module fdi_drive_model
  import fdi_pkg::*;
#(
  parameter int REV_CYC = 3000
) (
  // Clock
  input wire logic aclk,
  // Pins
  input wire fdi_drv_out_t drv_out,
  output var fdi_drv_in_t drv_in,
  // Bench controls
  input wire logic prot,
  input wire logic hd,
  input wire logic chg,
  output var int cyl
);
  int rev = 0;
  logic step_q = 1'b1;
  logic tog = 1'b0;
  logic sel_q = 1'b1;
  logic swap_l = 1'b0;
  initial cyl = 0;
  always @(posedge aclk) begin
    step_q <= drv_out.step_n;
    sel_q <= drv_out.sel_n;
    // flag held until reinsert plus deselect strobe
    if (chg) swap_l <= 1'b1;
    else if (drv_out.sel_n && !sel_q) swap_l <= 1'b0;
    tog <= !tog;
    if (!drv_out.sel_n && drv_out.step_n && !step_q)
      cyl <= drv_out.dir_out ? ((cyl > 0) ? cyl - 1 : 0) : cyl + 1;
    rev <= (drv_out.motor_n || rev == REV_CYC - 1) ? 0 : rev + 1;
  end
  // Deselected: status floats high, read line is noise
  always_comb begin
    drv_in = '1;
    drv_in.rd_data = tog;
    if (!drv_out.sel_n) begin
      drv_in.index_n = !(rev < 4 && !drv_out.motor_n);
      drv_in.outer_cyl_n = (cyl != 0);
      drv_in.wp_n = !prot;
      drv_in.hd_n = !hd;
      drv_in.swapped_n = !swap_l;
      drv_in.rd_data = rev[3];
    end
  end
endmodule // fdi_drive_model
`default_nettype wire

/* tb/fdi_ctrl_bench.sv */
/* Self-checking bench for fdi_ctrl with a drive model.
   Assumes package, core, checker and model compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module fdi_ctrl_bench;
  import fdi_pkg::*;
  logic aclk, aresetn, clk_en, prot, hd, chg, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp;
  fdi_drv_in_t din;
  fdi_drv_out_t dout;
  int error_cnt, num_checks, cyl;
  fdi_ctrl DUT (.aclk, .aresetn, .clk_en, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .drv_in(din), .drv_out(dout), .irq);
  fdi_drive_model #(.REV_CYC(3000)) u_drv (.aclk, .drv_out(dout),
    .drv_in(din), .prot, .hd, .chg, .cyl);
  // ------------------------------------------------------------
  // Bus tasks and scenarios
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awready && awvalid;
      hw = wready && wvalid;
      hb = bvalid;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arready && arvalid;
      hr = rvalid;
      d = rdata;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask
  task automatic t_pins();
    @(negedge aclk);
    `CHK(dout, 8'hDE)
    rd(ADDR_CTRL, v);
    `CHK(v[8:0], 9'h010)
    wr(ADDR_CTRL, 32'h0000000F);
    `CHK(dout, 8'h32)
    wr(ADDR_CTRL, 32'h00000011);
    `CHK(dout, 8'h5E)
  endtask
  task automatic t_seek();
    int n;
    rd(ADDR_STAT, v);
    `CHK(v[1], 1'b1)
    wr(ADDR_IRQ_MASK, 32'h00000002);
    wr(ADDR_SEEK, 32'h00000001);
    for (n = 0; n < 80000 && irq !== 1'b1; n++) @(posedge aclk);
    `CHK(cyl, 1)
    rd(ADDR_STAT, v);
    `CHK(v[1], 1'b0)
    rd(ADDR_IRQ_STAT, v);
    `CHK(v[1], 1'b1)
    @(negedge aclk);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_index();
    wr(ADDR_IRQ_MASK, 32'h00000000);
    wr(ADDR_CTRL, 32'h00000013);
    repeat (3010) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STAT, v);
    `CHK(v[0], 1'b1)
    wr(ADDR_IRQ_MASK, 32'h00000001);
    repeat (3010) @(posedge aclk);
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STAT, v);
    wr(ADDR_CTRL, 32'h00000011);
    // Spinning drive filled the buffer; drain it for later tests
    rd(ADDR_FILL, v);
    `CHK(v[4:0] != 5'h00, 1'b1)
    for (int i = v[4:0]; i > 0; i--) rd(ADDR_FIFO, v);
    rd(ADDR_FILL, v);
    `CHK(v[4:0], 5'h00)
  endtask
  task automatic t_wp();
    prot <= 1'b1;
    wr(ADDR_IRQ_MASK, 32'h00000008);
    wr(ADDR_CTRL, 32'h00000031);
    `CHK(dout.rec_en_n, 1'b1)
    `CHK(irq, 1'b1)
    rd(ADDR_CTRL, v);
    `CHK(v[5], 1'b0)
    rd(ADDR_IRQ_STAT, v);
    prot <= 1'b0;
    wr(ADDR_CTRL, 32'h00000031);
    `CHK(dout.rec_en_n, 1'b0)
    prot <= 1'b1;
    repeat (2) @(negedge aclk);
    `CHK(dout.rec_en_n, 1'b1)
    prot <= 1'b0;
    wr(ADDR_CTRL, 32'h00000011);
  endtask
  task automatic t_swap();
    wr(ADDR_IRQ_MASK, 32'h00000004);
    hd <= 1'b1;
    chg <= 1'b1;
    repeat (4) @(negedge aclk);
    `CHK(irq, 1'b1)
    rd(ADDR_STAT, v);
    `CHK(v[4:3], 2'b11)
    chg <= 1'b0;
    rd(ADDR_STAT, v);
    `CHK(v[3], 1'b1)
    wr(ADDR_CTRL, 32'h00000111);
    rd(ADDR_STAT, v);
    `CHK(v[3], 1'b0)
    rd(ADDR_IRQ_STAT, v);
  endtask
  task automatic t_fifo();
    wr(ADDR_CTRL, 32'h00000010);
    for (int i = 0; i < 16; i++) wr(ADDR_FIFO, 32'hA0 + i);
    rd(ADDR_FILL, v);
    `CHK(v[4:0], 5'h10)
    rd(ADDR_FIFO, v);
    `CHK(v[7:0], 8'hA0)
    rd(ADDR_FILL, v);
    `CHK(v[4:0], 5'h0F)
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, v);
    `CHK(v, 32'h00000000)
  endtask
  task automatic t_rate();
    // Burst write at 250k: request only once fill drops to eight
    rd(ADDR_IRQ_STAT, v);
    wr(ADDR_IRQ_MASK, 32'h00000010);
    wr(ADDR_CTRL, 32'h000000F3);
    repeat (4000) @(negedge aclk);
    `CHK(irq, 1'b0)
    repeat (3000) @(negedge aclk);
    `CHK(irq, 1'b1)
    wr(ADDR_CTRL, 32'h00000011);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    #(100_000 * 40);
    error_cnt++;
    end_of_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {prot, hd, chg, awaddr, araddr, wdata} = '0;
    clk_en = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_pins();
    t_seek();
    t_index();
    t_wp();
    t_swap();
    t_fifo();
    t_rate();
    end_of_test();
  end
endmodule // fdi_ctrl_bench
`default_nettype wire
